// ==== apmc_pkg.sv ====
// Constants and types for the converter and power mode control block
package apmc_pkg;
    // Serial frame layout
    localparam int FRAME_BITS = 24;
    localparam int READ_START = 8;
    localparam int RW_POS = 21;
    localparam int ADDR_HI = 20;
    localparam int ADDR_LO = 16;
    localparam int CMD_RW_POS = 5;
    localparam int CMD_ADDR_HI = 4;

    // Register addresses
    localparam logic [4:0] ADDR_RESULT = 5'h00;
    localparam logic [4:0] ADDR_CONV_CTRL = 5'h01;
    localparam logic [4:0] ADDR_MISC_ONE = 5'h02;
    localparam logic [4:0] ADDR_MISC_TWO = 5'h03;
    localparam logic [4:0] ADDR_POWER = 5'h09;

    // Reset values
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [15:0] RST_CONV_CTRL = 16'h01c3;
    localparam logic [15:0] RST_MISC_ONE = 16'h8000;
    localparam logic [15:0] RST_MISC_TWO = 16'h7fff;
    localparam logic [15:0] RST_POWER = 16'h0000;

    // Converter control field positions
    localparam int START_BUSY_POS = 15;
    localparam int SEL_HI = 13;
    localparam int SEL_LO = 11;
    localparam int SLEEP_POS = 7;
    localparam int RATE_HI = 6;
    localparam int RATE_LO = 4;

    // Power control field positions
    localparam int DAC_SLEEP_POS = 3;
    localparam int CHIP_WAKE_POS = 2;
    localparam int BODY_WAKE_POS = 1;
    localparam int WEIGHT_WAKE_POS = 0;

    // Ready pulse length in continuous mode
    localparam int READY_PULSE_NS = 8000;

    typedef enum logic [2:0] {
        APMC_FULL_DOWN, APMC_SLEEP, APMC_BODY_MEAS, APMC_WEIGHT_MEAS,
        APMC_AUX_MEAS, APMC_UNDEFINED
    } apmc_mode_t;

    // Complete state of the block
    typedef struct packed {
        logic [1:0] sync_ste_n;
        logic [1:0] sync_sclk;
        logic [1:0] sync_sdin;
        logic sclk_prev;
        logic [4:0] bit_cnt;
        logic [23:0] shift_in;
        logic [15:0] shift_out;
        logic is_read;
        logic [15:0] result;
        logic [15:0] conv_ctrl;
        logic [15:0] misc_fixed_one;
        logic [15:0] misc_fixed_two;
        logic [15:0] power_control;
        logic ss_busy;
        logic [31:0] conv_cnt;
        logic [15:0] pulse_cnt;
        logic ready_hold;
        logic sdout;
        logic sdout_oe_n;
        logic ready_n;
        logic converter_power;
        logic [2:0] input_selection;
        logic [2:0] data_rate;
        logic dac_power;
        logic chip_wake;
        logic body_chain_wake;
        logic weight_chain_wake;
        apmc_mode_t power_mode;
    } apmc_state_t;
endpackage : apmc_pkg

// ==== apmc_top.sv ====
// Converter control, power mode decode and serial register port
`timescale 1ns/1ns
// Functional notes
// - Result register holds latest conversion as 16-bit two's complement.
// - Start bit write accepted only while converter sleeps; test also writes it while awake.
// - Writing start bit 0 does nothing; writing 1 starts single shot.
// - Start bit reads 0 while converting, 1 while idle.
// - Input code 000 differential, 001 first input, 010 second input.
// - Bits 3:0 reset to 0011; host writes 0000.
// - Sleep bit resets to 1; converter idle while start bit 0.
// - Sleep bit 0 converts continuously regardless of start bit.
// - Sleep and start both 1: one conversion, then idle again.
// - Rate field picks 8 to 860 samples per second.
// - First misc register resets to 8000; host writes zeros.
// - Second misc register resets to 7fff; host writes ones.
// - Power bit 3 low wakes both DACs while bit 2 is set, high sleeps them.
// - Power bit 2 is master front-end wake, default asleep.
// - Decode full power down and sleep modes from power bits.
// - Decode body, weight and auxiliary measurement modes.
// - Serial frame with bit 21 clear writes data to addressed register.
module apmc_top #(
    parameter int CLK_HZ = 50_000_000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ste_n,
    input wire logic sclk,
    input wire logic sdin,
    input wire logic [15:0] sample,
    output logic sdout,
    output logic sdout_oe_n,
    output logic ready_n,
    output logic converter_power,
    output logic [2:0] input_selection,
    output logic [2:0] data_rate,
    output logic dac_power,
    output logic chip_wake,
    output logic body_chain_wake,
    output logic weight_chain_wake,
    output apmc_pkg::apmc_mode_t power_mode
);
    // Pulse length derived from the clock rate, kept under 16 bits
    localparam int PULSE_CYC =
        (CLK_HZ / 1_000_000) * apmc_pkg::READY_PULSE_NS / 1000;
    localparam logic [15:0] PULSE_CYCLES = 16'(PULSE_CYC);

    // Slowest rate needs most cycles; fastest must leave room for a pulse
    if (CLK_HZ < 1_000_000 || PULSE_CYC > 16'hffff
        || PULSE_CYC < 1) begin : g_bad_clk
        $error("apmc_top: CLK_HZ out of range");
    end

    apmc_pkg::apmc_state_t r;
    apmc_pkg::apmc_state_t n;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
    logic conv_done;
    logic ss_start;

    // Cycles per conversion at each rate code
    function automatic logic [31:0] rate_cycles(input logic [2:0] code);
        case (code)
            3'h0: rate_cycles = 32'(CLK_HZ / 8);
            3'h1: rate_cycles = 32'(CLK_HZ / 16);
            3'h2: rate_cycles = 32'(CLK_HZ / 32);
            3'h3: rate_cycles = 32'(CLK_HZ / 64);
            3'h4: rate_cycles = 32'(CLK_HZ / 128);
            3'h5: rate_cycles = 32'(CLK_HZ / 250);
            3'h6: rate_cycles = 32'(CLK_HZ / 475);
            default: rate_cycles = 32'(CLK_HZ / 860);
        endcase
    endfunction : rate_cycles

    // Table of power states from power bits and converter sleep
    function automatic apmc_pkg::apmc_mode_t decode_mode(
        input logic [15:0] p, input logic sleep);
        logic [3:0] b;
        b = p[3:0];
        decode_mode = apmc_pkg::APMC_UNDEFINED;
        if (b[2:0] == 3'h0 && sleep) begin
            decode_mode = apmc_pkg::APMC_FULL_DOWN;
        end else if (b == 4'hc && sleep) begin
            decode_mode = apmc_pkg::APMC_SLEEP;
        end else if (b[3:2] == 2'h1 && !sleep) begin
            case (b[1:0])
                2'h2: decode_mode = apmc_pkg::APMC_BODY_MEAS;
                2'h1: decode_mode = apmc_pkg::APMC_WEIGHT_MEAS;
                2'h0: decode_mode = apmc_pkg::APMC_AUX_MEAS;
                default: decode_mode = apmc_pkg::APMC_UNDEFINED;
            endcase
        end
    endfunction : decode_mode

    // Register read view; start bit shows idle status
    function automatic logic [15:0] read_value(
        input apmc_pkg::apmc_state_t s, input logic [4:0] a);
        read_value = 16'h0000;
        if (a == apmc_pkg::ADDR_RESULT) begin
            read_value = s.result;
        end else if (a == apmc_pkg::ADDR_CONV_CTRL) begin
            read_value = s.conv_ctrl;
            read_value[apmc_pkg::START_BUSY_POS] =
                !(!s.conv_ctrl[apmc_pkg::SLEEP_POS] || s.ss_busy);
        end else if (a == apmc_pkg::ADDR_MISC_ONE) begin
            read_value = s.misc_fixed_one;
        end else if (a == apmc_pkg::ADDR_MISC_TWO) begin
            read_value = s.misc_fixed_two;
        end else if (a == apmc_pkg::ADDR_POWER) begin
            read_value = s.power_control;
        end
    endfunction : read_value

    // Next state of the whole block
    always_comb begin
        logic [23:0] sh;
        logic [4:0] cnt;
        logic fall;
        logic rise;
        sh = 24'h00_0000;
        cnt = 5'h00;
        fall = r.sclk_prev && !r.sync_sclk[1];
        rise = !r.sclk_prev && r.sync_sclk[1];
        n = r;
        wr_en = 1'b0;
        wr_addr = 5'h00;
        wr_data = 16'h0000;
        conv_done = 1'b0;
        ss_start = 1'b0;
        // Pins pass two flops before use
        n.sync_ste_n = {r.sync_ste_n[0], ste_n};
        n.sync_sclk = {r.sync_sclk[0], sclk};
        n.sync_sdin = {r.sync_sdin[0], sdin};
        n.sclk_prev = r.sync_sclk[1];
        // Serial frame; select high resets the port and ignores the clock
        if (r.sync_ste_n[1]) begin
            n.bit_cnt = 5'h00;
            n.is_read = 1'b0;
        end else if (fall && r.bit_cnt < 5'(apmc_pkg::FRAME_BITS)) begin
            sh = {r.shift_in[22:0], r.sync_sdin[1]};
            cnt = r.bit_cnt + 5'h01;
            n.shift_in = sh;
            n.bit_cnt = cnt;
            if (cnt == 5'(apmc_pkg::READ_START)) begin
                n.is_read = sh[apmc_pkg::CMD_RW_POS];
                n.shift_out = read_value(r, sh[apmc_pkg::CMD_ADDR_HI:0]);
            end
            if (cnt == 5'(apmc_pkg::FRAME_BITS)
                && !sh[apmc_pkg::RW_POS]) begin
                wr_en = 1'b1;
                wr_addr = sh[apmc_pkg::ADDR_HI:apmc_pkg::ADDR_LO];
                wr_data = sh[15:0];
            end
        end else if (rise && r.is_read
                     && r.bit_cnt >= 5'(apmc_pkg::READ_START)) begin
            n.sdout = r.shift_out[15];
            n.shift_out = {r.shift_out[14:0], 1'b0};
        end
        // Register writes; unmapped addresses are dropped
        if (wr_en) begin
            if (wr_addr == apmc_pkg::ADDR_CONV_CTRL) begin
                // Start honoured only from sleep and with sleep kept set
                ss_start = r.conv_ctrl[apmc_pkg::SLEEP_POS]
                    && wr_data[apmc_pkg::START_BUSY_POS]
                    && wr_data[apmc_pkg::SLEEP_POS] && !r.ss_busy;
                n.conv_ctrl = {1'b0, wr_data[14:0]};
            end else if (wr_addr == apmc_pkg::ADDR_MISC_ONE) begin
                n.misc_fixed_one = wr_data;
            end else if (wr_addr == apmc_pkg::ADDR_MISC_TWO) begin
                n.misc_fixed_two = wr_data;
            end else if (wr_addr == apmc_pkg::ADDR_POWER) begin
                n.power_control = wr_data;
            end
        end
        // Conversion engine: continuous when awake, else one shot
        if (ss_start) begin
            n.ss_busy = 1'b1;
            n.conv_cnt = 32'h0000_0000;
            n.ready_hold = 1'b0;
        end else if (!r.conv_ctrl[apmc_pkg::SLEEP_POS] || r.ss_busy) begin
            if (r.conv_cnt >= rate_cycles(r.conv_ctrl[6:4]) - 32'h0000_0001)
            begin
                conv_done = 1'b1;
                n.result = sample;
                n.conv_cnt = 32'h0000_0000;
                if (r.ss_busy && r.conv_ctrl[apmc_pkg::SLEEP_POS]) begin
                    n.ss_busy = 1'b0;
                    n.ready_hold = 1'b1;
                end else begin
                    n.ss_busy = 1'b0;
                    n.ready_hold = 1'b0;
                    n.pulse_cnt = PULSE_CYCLES;
                end
            end else begin
                n.conv_cnt = r.conv_cnt + 32'h0000_0001;
            end
        end else begin
            n.conv_cnt = 32'h0000_0000;
        end
        if (!conv_done && r.pulse_cnt != 16'h0000) begin
            n.pulse_cnt = r.pulse_cnt - 16'h0001;
        end
        // Registered outputs from next state
        n.ready_n = !(n.pulse_cnt != 16'h0000 || n.ready_hold);
        n.sdout_oe_n = r.sync_ste_n[1];
        n.converter_power = !n.conv_ctrl[apmc_pkg::SLEEP_POS] || n.ss_busy;
        // Reserved input codes are passed through unchanged
        n.input_selection =
            n.conv_ctrl[apmc_pkg::SEL_HI:apmc_pkg::SEL_LO];
        n.data_rate = n.conv_ctrl[apmc_pkg::RATE_HI:apmc_pkg::RATE_LO];
        n.chip_wake = n.power_control[apmc_pkg::CHIP_WAKE_POS];
        n.dac_power = n.chip_wake
            && !n.power_control[apmc_pkg::DAC_SLEEP_POS];
        n.body_chain_wake = n.chip_wake
            && n.power_control[apmc_pkg::BODY_WAKE_POS];
        n.weight_chain_wake = n.chip_wake
            && n.power_control[apmc_pkg::WEIGHT_WAKE_POS];
        n.power_mode = decode_mode(n.power_control,
            n.conv_ctrl[apmc_pkg::SLEEP_POS]);
    end

    // State register; reset values are constants only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.sync_ste_n <= 2'h3;
            r.sdout_oe_n <= 1'b1;
            r.ready_n <= 1'b1;
            r.result <= apmc_pkg::RST_RESULT;
            r.conv_ctrl <= apmc_pkg::RST_CONV_CTRL;
            r.misc_fixed_one <= apmc_pkg::RST_MISC_ONE;
            r.misc_fixed_two <= apmc_pkg::RST_MISC_TWO;
            r.power_control <= apmc_pkg::RST_POWER;
            r.data_rate <= apmc_pkg::RST_CONV_CTRL[6:4];
            r.power_mode <= apmc_pkg::APMC_FULL_DOWN;
        end else begin
            r <= n;
        end
    end

    assign sdout = r.sdout;
    assign sdout_oe_n = r.sdout_oe_n;
    assign ready_n = r.ready_n;
    assign converter_power = r.converter_power;
    assign input_selection = r.input_selection;
    assign data_rate = r.data_rate;
    assign dac_power = r.dac_power;
    assign chip_wake = r.chip_wake;
    assign body_chain_wake = r.body_chain_wake;
    assign weight_chain_wake = r.weight_chain_wake;
    assign power_mode = r.power_mode;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_result_capture;
        conv_done |=> r.result == $past(sample);
    endproperty
    a_result_capture: assert property (p_result_capture)
        else $error("result not captured");

    property p_start_gate;
        ss_start |-> r.conv_ctrl[apmc_pkg::SLEEP_POS] && !r.ss_busy
            && wr_addr == apmc_pkg::ADDR_CONV_CTRL;
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("single shot started while awake");

    property p_start_effect;
        ss_start |=> r.ss_busy ##1 r.converter_power;
    endproperty
    a_start_effect: assert property (p_start_effect)
        else $error("single shot did not start");

    property p_busy_read;
        r.ss_busy |-> (read_value(r, apmc_pkg::ADDR_CONV_CTRL)
            & 16'h8000) == 16'h0000;
    endproperty
    a_busy_read: assert property (p_busy_read)
        else $error("busy bit not low while converting");

    property p_sleep_idle;
        r.conv_ctrl[apmc_pkg::SLEEP_POS] && !r.ss_busy && !ss_start
            |=> r.conv_cnt == 32'h0000_0000;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle)
        else $error("converter ran while asleep");

    property p_continuous;
        !r.conv_ctrl[apmc_pkg::SLEEP_POS] [*2]
            |-> r.conv_cnt != $past(r.conv_cnt) || $past(conv_done);
    endproperty
    a_continuous: assert property (p_continuous)
        else $error("continuous conversion stalled");

    property p_single_end;
        conv_done && r.ss_busy && r.conv_ctrl[apmc_pkg::SLEEP_POS]
            |=> !r.ss_busy && !r.ready_n && !r.converter_power;
    endproperty
    a_single_end: assert property (p_single_end)
        else $error("single shot did not finish");

    property p_rate_spacing;
        conv_done |=> !conv_done [*8];
    endproperty
    a_rate_spacing: assert property (p_rate_spacing)
        else $error("conversions too close");

    property p_sleep_mode;
        r.power_control[3:0] == 4'hc && r.conv_ctrl[apmc_pkg::SLEEP_POS]
            |-> r.power_mode == apmc_pkg::APMC_SLEEP;
    endproperty
    a_sleep_mode: assert property (p_sleep_mode)
        else $error("sleep mode not decoded");

    property p_weight_mode;
        r.power_control[3:0] == 4'h5 && !r.conv_ctrl[apmc_pkg::SLEEP_POS]
            |-> r.power_mode == apmc_pkg::APMC_WEIGHT_MEAS && r.dac_power;
    endproperty
    a_weight_mode: assert property (p_weight_mode)
        else $error("weight mode not decoded");

    property p_write_misc;
        wr_en && wr_addr == apmc_pkg::ADDR_MISC_TWO
            |=> r.misc_fixed_two == $past(wr_data);
    endproperty
    a_write_misc: assert property (p_write_misc)
        else $error("register write lost");

    c_single: cover property (conv_done && r.ss_busy);
    c_continuous: cover property (conv_done && !r.ss_busy);
    c_write: cover property (wr_en);
    c_read: cover property (r.is_read && !r.sdout_oe_n);
endmodule : apmc_top

// ==== apmc_host_model.sv ====
// Host controller model driving the serial register port
`timescale 1ns/1ns
module apmc_host_model (
    input wire logic clk,
    output logic ste_n,
    output logic sclk,
    output logic sdin,
    input wire logic sdout
);
    // Idle bus: deselected, clock parked low
    initial begin
        ste_n = 1'b1;
        sclk = 1'b0;
        sdin = 1'b0;
    end

    // One 24-bit frame, MSB first, 4 clk per sclk phase
    task automatic xfer(input logic rd, input logic [4:0] addr,
                        input logic [15:0] data, output logic [15:0] rdata);
        logic [23:0] frm;
        frm = {2'b00, rd, addr, data};
        rdata = 16'h0000;
        @(posedge clk);
        ste_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 23; i >= 0; i--) begin
            sclk <= 1'b1;
            sdin <= frm[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
            // Sampled late so the synchroniser lag has settled
            if (rd && i < 16) begin
                rdata[i] = sdout;
            end
        end
        // Released data line shows the inverse, never a stale bit
        ste_n <= 1'b1;
        sdin <= ~frm[0];
        repeat (4) @(posedge clk);
    endtask : xfer
endmodule : apmc_host_model

// ==== tb_top.sv ====
// Self-checking testbench for the converter and power mode block
`timescale 1ns/1ns
module tb_top;
    // Smallest safe rate keeps conversions short
    localparam int CLK_HZ = 1_000_000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] sample = 16'h0000;
    wire logic ste_n, sclk, sdin;
    logic sdout, sdout_oe_n, ready_n, converter_power;
    logic [2:0] input_selection, data_rate;
    logic dac_power, chip_wake, body_chain_wake, weight_chain_wake;
    apmc_pkg::apmc_mode_t power_mode;
    int fail_count = 0;
    int check_count = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    apmc_top #(.CLK_HZ(CLK_HZ)) u_apmc_top (.clk(clk), .rst(rst),
        .ste_n(ste_n), .sclk(sclk), .sdin(sdin), .sample(sample),
        .sdout(sdout), .sdout_oe_n(sdout_oe_n), .ready_n(ready_n),
        .converter_power(converter_power),
        .input_selection(input_selection), .data_rate(data_rate),
        .dac_power(dac_power), .chip_wake(chip_wake),
        .body_chain_wake(body_chain_wake),
        .weight_chain_wake(weight_chain_wake), .power_mode(power_mode));

    apmc_host_model u_apmc_host_model (.clk(clk), .ste_n(ste_n),
        .sclk(sclk), .sdin(sdin), .sdout(sdout));

    task automatic report_and_stop;
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] unused;
        u_apmc_host_model.xfer(1'b0, a, d, unused);
    endtask : wr

    task automatic rd_chk(input string what, input logic [4:0] a,
                          input logic [15:0] exp);
        logic [15:0] got;
        u_apmc_host_model.xfer(1'b1, a, 16'h0000, got);
        chk(what, exp, got);
    endtask : rd_chk

    // Host always writes fixed bits 14, 10:8 and 3:0 correctly
    function automatic logic [15:0] cfg(input logic st, input logic [2:0] sel,
                                        input logic slp, input logic [2:0] r);
        return {st, 1'b1, sel, 3'b001, slp, r, 4'h0};
    endfunction : cfg

    // Bounded wait for a ready level, counting edges
    task automatic wait_ready(input logic lvl, output int n);
        n = 0;
        while (ready_n !== lvl && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("ready_n level", {15'h0, lvl}, {15'h0, ready_n});
    endtask : wait_ready

    task automatic t_reset;
        chk("data_rate", 16'h0004, {13'h0, data_rate});
        chk("sdout_oe_n", 16'h0001, {15'h0, sdout_oe_n});
        chk("ready_n", 16'h0001, {15'h0, ready_n});
        chk("converter_power", 16'h0000, {15'h0, converter_power});
        chk("power_mode", 16'h0000, {13'h0, power_mode});
        rd_chk("result", apmc_pkg::ADDR_RESULT, 16'h0000);
        rd_chk("conv_ctrl", apmc_pkg::ADDR_CONV_CTRL, 16'h81c3);
        rd_chk("misc one", apmc_pkg::ADDR_MISC_ONE, 16'h8000);
        rd_chk("misc two", apmc_pkg::ADDR_MISC_TWO, 16'h7fff);
        rd_chk("power", apmc_pkg::ADDR_POWER, 16'h0000);
    endtask : t_reset

    // Read-only and unmapped places must swallow writes
    task automatic t_regs;
        wr(apmc_pkg::ADDR_MISC_ONE, 16'h0000);
        wr(apmc_pkg::ADDR_MISC_TWO, 16'hffff);
        wr(apmc_pkg::ADDR_RESULT, 16'h1234);
        wr(5'h05, 16'h5a5a);
        rd_chk("misc one", apmc_pkg::ADDR_MISC_ONE, 16'h0000);
        rd_chk("misc two", apmc_pkg::ADDR_MISC_TWO, 16'hffff);
        rd_chk("result", apmc_pkg::ADDR_RESULT, 16'h0000);
        rd_chk("unmapped", 5'h05, 16'h0000);
    endtask : t_regs

    task automatic t_config;
        logic [15:0] v;
        for (int r = 0; r < 8; r++) begin
            v = cfg(1'b0, 3'(r), 1'b1, 3'(r));
            wr(apmc_pkg::ADDR_CONV_CTRL, v);
            chk("sel", 16'(r), {13'h0, input_selection});
            chk("data_rate", 16'(r), {13'h0, data_rate});
            chk("conv power", 16'h0000, {15'h0, converter_power});
            rd_chk("conv_ctrl", apmc_pkg::ADDR_CONV_CTRL, v | 16'h8000);
        end
    endtask : t_config

    task automatic t_continuous;
        int n;
        int m;
        sample <= 16'h1234;
        wr(apmc_pkg::ADDR_CONV_CTRL, cfg(1'b0, 3'h0, 1'b0, 3'h7));
        chk("conv power", 16'h0001, {15'h0, converter_power});
        wait_ready(1'b0, n);
        sample <= 16'hfedc;
        wait_ready(1'b1, n);
        chk("ready pulse", 16'(CLK_HZ / 125_000), 16'(n));
        wait_ready(1'b0, m);
        chk("period", 16'(CLK_HZ / 860), 16'(m + n));
        rd_chk("result", apmc_pkg::ADDR_RESULT, 16'hfedc);
        // Start with converter awake is refused, converter sleeps
        wr(apmc_pkg::ADDR_CONV_CTRL, cfg(1'b1, 3'h0, 1'b1, 3'h7));
        chk("conv power", 16'h0000, {15'h0, converter_power});
        rd_chk("conv_ctrl", 5'h01, cfg(1'b1, 3'h0, 1'b1, 3'h7));
    endtask : t_continuous

    task automatic t_single;
        int n;
        sample <= 16'h8001;
        wr(apmc_pkg::ADDR_CONV_CTRL, cfg(1'b1, 3'h0, 1'b1, 3'h7));
        chk("conv power", 16'h0001, {15'h0, converter_power});
        rd_chk("busy", 5'h01, cfg(1'b0, 3'h0, 1'b1, 3'h7));
        wait_ready(1'b0, n);
        repeat (2) @(posedge clk);
        chk("conv power", 16'h0000, {15'h0, converter_power});
        rd_chk("result", apmc_pkg::ADDR_RESULT, 16'h8001);
        rd_chk("idle", 5'h01, cfg(1'b1, 3'h0, 1'b1, 3'h7));
        chk("ready held", 16'h0000, {15'h0, ready_n});
    endtask : t_single

    task automatic t_power;
        logic [15:0] pw [5];
        apmc_pkg::apmc_mode_t md [5];
        logic [15:0] e;
        logic [15:0] g;
        pw = '{16'h6000, 16'h600c, 16'h6006, 16'h6005, 16'h6004};
        md = '{apmc_pkg::APMC_FULL_DOWN, apmc_pkg::APMC_SLEEP,
               apmc_pkg::APMC_BODY_MEAS, apmc_pkg::APMC_WEIGHT_MEAS,
               apmc_pkg::APMC_AUX_MEAS};
        for (int k = 0; k < 5; k++) begin
            wr(5'h01, cfg(1'b0, 3'h0, k < 2, 3'h7));
            wr(apmc_pkg::ADDR_POWER, pw[k]);
            rd_chk("power", apmc_pkg::ADDR_POWER, pw[k]);
            chk("mode", {13'h0, md[k]}, {13'h0, power_mode});
            e = {12'h0, pw[k][2] & ~pw[k][3], pw[k][2],
                 pw[k][2] & pw[k][1], pw[k][2] & pw[k][0]};
            g = {12'h0, dac_power, chip_wake, body_chain_wake,
                 weight_chain_wake};
            chk("wake outputs", e, g);
        end
    endtask : t_power

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_regs();
        t_config();
        t_continuous();
        t_single();
        t_power();
        report_and_stop();
    end

    // Watchdog, generous against roughly 14k cycles of traffic
    initial begin
        repeat (80_000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
endmodule : tb_top
